// ### hdl/eesfe_pkg.sv
// eesfe_pkg: shared constants and types of the serial memory front end
// What this block does
// - read data driven MSB first on falling edge
// - serial_in sampled on rising edge, MSB first
// - deselect floats serial_out at once
// - active while selected, standby unless writing
// - clock may idle low or high
// - pause starts when pause_n low, clock low
// - paused: output floats, counters hold, serial_in still shifts on rising edges
// - pause ends when pause_n high, clock low
// - deselect during pause is a plain deselect; whole-byte writes still launch
// - no command before first falling select edge
// - writes need write_arm_latch set beforehand
// - writes need falling select, low throughout
// - write bit count must be whole bytes
// - write needs at least one data byte
// - write launches on select rise at boundary
// - select rise off boundary discards write
// - read needs whole instruction and address bytes
// - read data streams until select rises
// - unknown instruction waits for deselect
// - commands open with 8-bit instruction, MSB first
// - memory commands carry 16-bit address, high first
package eesfe_pkg;
  // instruction codes
  localparam logic [7:0] CMD_ARM = 8'h06;
  localparam logic [7:0] CMD_DISARM = 8'h04;
  localparam logic [7:0] CMD_STAT_FETCH = 8'h05;
  localparam logic [7:0] CMD_STAT_STORE = 8'h01;
  localparam logic [7:0] CMD_ARRAY_FETCH = 8'h03;
  localparam logic [7:0] CMD_ARRAY_STORE = 8'h02;
  localparam logic [7:0] CMD_IDENT_FETCH = 8'h83;
  localparam logic [7:0] CMD_IDENT_STORE = 8'h82;
  // address bit that turns ident page access into lock access
  localparam int ADDR_LOCK_BIT = 10;
  // page buffer and modelled store
  localparam int PAGE_AW = 7;
  localparam int PAGE_DEPTH = 128;
  localparam int MEM_DEPTH = 256;
  // status byte layout
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_ARM_BIT = 1;
  localparam int STAT_BP_LSB = 2;
  localparam int STAT_SRWD_BIT = 7;
  localparam logic [7:0] STAT_STORE_MASK = 8'h8c;
  localparam logic [7:0] STAT_RST = 8'h00;
  // link clock made by the master from mclk
  localparam int MCLK_PERIOD_NS = 4;
  localparam int LINK_HALF_NS = 24;
  localparam int LINK_HALF_CYC = LINK_HALF_NS / MCLK_PERIOD_NS;
  localparam logic [3:0] LINK_DIV_LAST = 4'(LINK_HALF_CYC - 1);

  typedef enum logic [5:0] {
    F_CMD = 6'b000001,
    F_ADDR_HI = 6'b000010,
    F_ADDR_LO = 6'b000100,
    F_DATA = 6'b001000,
    F_READ = 6'b010000,
    F_WAIT = 6'b100000
  } eesfe_frame_t;

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_COPY = 3'b010,
    W_FIN = 3'b100
  } eesfe_wcyc_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LEAD = 4'b0010,
    H_SHIFT = 4'b0100,
    H_TAIL = 4'b1000
  } eesfe_host_t;
endpackage : eesfe_pkg

// ### hdl/eesfe_link_if.sv
// eesfe_link_if: serial link pins between master and memory front end
`timescale 1ns/10ps
interface eesfe_link_if;
  logic sclk;
  logic pick_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic pause_n;
  logic wp_n;
  logic sdo_line;

  // the line as the master sees it: pulled high while the memory floats it
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (
    input sclk,
    input pick_n,
    input sdi,
    input pause_n,
    input wp_n,
    output sdo,
    output sdo_oe
  );

  modport mst (
    output sclk,
    output pick_n,
    output sdi,
    output pause_n,
    output wp_n,
    input sdo_line
  );
endinterface : eesfe_link_if

// ### hdl/eesfe_dev.sv
// eesfe_dev: memory end of the serial link with a small modelled store
`timescale 1ns/10ps
module eesfe_dev (
  eesfe_link_if.dev link,
  input wire logic mclk_i,
  input wire logic rst_b_i,
  output logic busy_o,
  output logic armed_o,
  output logic standby_o,
  output logic commit_o,
  output logic drop_o,
  output logic [7:0] commit_cmd_o,
  output logic [15:0] commit_addr_o,
  output logic [7:0] commit_len_o
);
  import eesfe_pkg::*;

  // link domain state, clocked by the master's serial clock
  logic first_reg;
  logic held_reg;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] byte_reg, byte_next;
  logic [7:0] didx_reg, didx_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [15:0] addr_reg, addr_next;
  eesfe_frame_t st_reg, st_next;
  logic [7:0] out_reg, out_next;
  logic [7:0] wbuf [0:PAGE_DEPTH-1];
  logic wbuf_we;
  logic [7:0] out_byte;
  logic paused;
  logic rd_reg, rd_next;
  // mclk domain state
  logic pk1_reg, pk2_reg, pk3_reg;
  logic fs1_reg, fs2_reg, fs3_reg;
  logic wp1_reg, wp2_reg;
  logic seen_reg, seen_next;
  logic arm_reg, arm_next;
  logic wip_reg, wip_next;
  logic lock_reg, lock_next;
  logic [7:0] stat_reg, stat_next;
  eesfe_wcyc_t wc_reg, wc_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] mem [0:MEM_DEPTH-1];
  logic mem_we;
  logic [7:0] mem_idx;
  logic commit_next, drop_next;
  logic [7:0] ccmd_next, clen_next;
  logic [15:0] caddr_next;
  logic frame_end, whole, is_store;

  // counters look cleared until the first rising edge of a selection
  always_ff @(posedge link.sclk or posedge link.pick_n) begin
    if (link.pick_n) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  // pause is decided while the clock is low; the rising edge keeps it
  assign paused = link.sclk ? held_reg : ~link.pause_n;

  // framing: instruction, address, data bytes counted per selection
  always_comb begin
    bit_next = first_reg ? 3'h0 : bit_reg;
    byte_next = first_reg ? 8'h00 : byte_reg;
    didx_next = first_reg ? 8'h00 : didx_reg;
    st_next = first_reg ? F_CMD : st_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    sh_next = {sh_reg[6:0], link.sdi};
    wbuf_we = 1'b0;
    if (link.pause_n) begin
      bit_next = bit_next + 3'h1;
      if (bit_next == 3'h0) begin
        if (byte_next != 8'hff) begin
          byte_next = byte_next + 8'h01;
        end
        case (st_next)
          F_CMD: begin
            cmd_next = sh_next;
            case (sh_next)
              CMD_ARRAY_FETCH, CMD_IDENT_FETCH, CMD_ARRAY_STORE, CMD_IDENT_STORE: begin
                st_next = F_ADDR_HI;
              end
              CMD_STAT_FETCH: begin
                st_next = F_READ;
              end
              CMD_STAT_STORE, CMD_ARM, CMD_DISARM: begin
                st_next = F_DATA;
              end
              default: begin
                st_next = F_WAIT;
              end
            endcase
          end
          F_ADDR_HI: begin
            addr_next[15:8] = sh_next;
            st_next = F_ADDR_LO;
          end
          F_ADDR_LO: begin
            addr_next[7:0] = sh_next;
            st_next = (cmd_reg[0]) ? F_READ : F_DATA;
          end
          F_DATA: begin
            wbuf_we = (didx_next < 8'(PAGE_DEPTH));
            if (didx_next != 8'hff) begin
              didx_next = didx_next + 8'h01;
            end
          end
          F_READ: begin
            addr_next = addr_reg + 16'h0001;
          end
          default: begin
            st_next = F_WAIT;
          end
        endcase
      end
    end else begin
      bit_next = bit_reg;
      byte_next = byte_reg;
      didx_next = didx_reg;
      st_next = st_reg;
    end
  end

  // no reset: results must outlive the selection for the write decision
  always_ff @(posedge link.sclk) begin
    held_reg <= ~link.pause_n;
    bit_reg <= bit_next;
    byte_reg <= byte_next;
    didx_reg <= didx_next;
    st_reg <= st_next;
    cmd_reg <= cmd_next;
    addr_reg <= addr_next;
    sh_reg <= sh_next;
    if (wbuf_we) begin
      wbuf[didx_next[PAGE_AW-1:0] - 7'h01] <= sh_next;
    end
  end

  // read source; a copy into the store can still run after a new selection begins
  always_comb begin
    if (cmd_reg == CMD_STAT_FETCH) begin
      out_byte = stat_reg;
    end else if (cmd_reg == CMD_IDENT_FETCH && addr_reg[ADDR_LOCK_BIT]) begin
      out_byte = {7'h00, lock_reg};
    end else begin
      out_byte = mem[{cmd_reg[7], addr_reg[PAGE_AW-1:0]}];
    end
  end

  // output shifter on the falling edge, loaded at each byte boundary
  always_comb begin
    rd_next = (st_reg == F_READ) & ~first_reg;
    if (!link.pause_n) begin
      out_next = out_reg;
    end else if (bit_reg == 3'h0) begin
      out_next = out_byte;
    end else begin
      out_next = {out_reg[6:0], 1'b0};
    end
  end

  always_ff @(negedge link.sclk) begin
    out_reg <= out_next;
  end

  // read phase opens at a falling edge, so the pin never shows a stale bit first
  always_ff @(negedge link.sclk or posedge link.pick_n) begin
    if (link.pick_n) begin
      rd_reg <= 1'b0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign link.sdo = out_reg[7];
  // select and pause act on the enable directly, not through a clock
  assign link.sdo_oe = rd_reg & ~link.pick_n & ~paused & seen_reg;

  // select and write-protect pins into mclk through two flops
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pk1_reg <= 1'b0;
      pk2_reg <= 1'b0;
      pk3_reg <= 1'b0;
      fs1_reg <= 1'b1;
      fs2_reg <= 1'b1;
      fs3_reg <= 1'b1;
      wp1_reg <= 1'b0;
      wp2_reg <= 1'b0;
    end else begin
      pk1_reg <= link.pick_n;
      pk2_reg <= pk1_reg;
      pk3_reg <= pk2_reg;
      fs1_reg <= first_reg;
      fs2_reg <= fs1_reg;
      fs3_reg <= fs2_reg;
      wp1_reg <= link.wp_n;
      wp2_reg <= wp1_reg;
    end
  end

  // a select already high at reset release, or low at power-up, is no frame end
  assign frame_end = pk2_reg & ~pk3_reg & seen_reg;
  // first_reg is set by the select rise itself, so it is read through the same delay;
  // fs3 then tells whether any clock came in this selection
  assign whole = (bit_reg == 3'h0) & ~fs3_reg & seen_reg;
  assign is_store = (cmd_reg == CMD_ARRAY_STORE) | (cmd_reg == CMD_IDENT_STORE) |
                    (cmd_reg == CMD_STAT_STORE);
  // copy uses the latched command, so a new selection cannot move the target
  assign mem_idx = {commit_cmd_o[7],
                    PAGE_AW'(commit_addr_o[PAGE_AW-1:0] + cnt_reg[PAGE_AW-1:0])};

  // write decision at deselect, then the copy into the store
  always_comb begin
    seen_next = seen_reg | pk2_reg;
    arm_next = arm_reg;
    wip_next = wip_reg;
    lock_next = lock_reg;
    stat_next = stat_reg;
    wc_next = wc_reg;
    cnt_next = cnt_reg;
    mem_we = 1'b0;
    commit_next = 1'b0;
    drop_next = 1'b0;
    ccmd_next = commit_cmd_o;
    caddr_next = commit_addr_o;
    clen_next = commit_len_o;
    case (wc_reg)
      W_IDLE: begin
        if (frame_end && whole && st_reg == F_DATA) begin
          if (cmd_reg == CMD_ARM && byte_reg == 8'h01) begin
            arm_next = 1'b1;
          end else if (cmd_reg == CMD_DISARM && byte_reg == 8'h01) begin
            arm_next = 1'b0;
          end else if (is_store && didx_reg != 8'h00 && arm_reg) begin
            if ((cmd_reg == CMD_IDENT_STORE && lock_reg) ||
                (cmd_reg == CMD_STAT_STORE && stat_reg[STAT_SRWD_BIT] && !wp2_reg)) begin
              drop_next = 1'b1;
            end else begin
              wip_next = 1'b1;
              cnt_next = 8'h00;
              ccmd_next = cmd_reg;
              caddr_next = addr_reg;
              clen_next = didx_reg;
              wc_next = W_COPY;
            end
          end else if (is_store) begin
            drop_next = 1'b1;
          end
        end else if (frame_end && is_store && st_reg == F_DATA) begin
          drop_next = 1'b1;
        end
      end
      W_COPY: begin
        if (commit_cmd_o == CMD_STAT_STORE) begin
          stat_next = wbuf[0] & STAT_STORE_MASK;
        end else if (commit_cmd_o == CMD_IDENT_STORE && commit_addr_o[ADDR_LOCK_BIT]) begin
          lock_next = 1'b1;
        end else begin
          mem_we = 1'b1;
        end
        cnt_next = cnt_reg + 8'h01;
        if (mem_we == 1'b0 || cnt_next == commit_len_o || cnt_next == 8'(PAGE_DEPTH)) begin
          wc_next = W_FIN;
        end
      end
      W_FIN: begin
        wip_next = 1'b0;
        arm_next = 1'b0;
        commit_next = 1'b1;
        wc_next = W_IDLE;
      end
      default: begin
        wc_next = W_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen_reg <= 1'b0;
      arm_reg <= 1'b0;
      wip_reg <= 1'b0;
      lock_reg <= 1'b0;
      stat_reg <= STAT_RST;
      wc_reg <= W_IDLE;
      cnt_reg <= 8'h00;
      commit_o <= 1'b0;
      drop_o <= 1'b0;
      commit_cmd_o <= 8'h00;
      commit_addr_o <= 16'h0000;
      commit_len_o <= 8'h00;
    end else begin
      seen_reg <= seen_next;
      arm_reg <= arm_next;
      wip_reg <= wip_next;
      lock_reg <= lock_next;
      stat_reg <= {stat_next[7:2], arm_next, wip_next};
      wc_reg <= wc_next;
      cnt_reg <= cnt_next;
      commit_o <= commit_next;
      drop_o <= drop_next;
      commit_cmd_o <= ccmd_next;
      commit_addr_o <= caddr_next;
      commit_len_o <= clen_next;
    end
  end

  // modelled store, no reset: contents are data, not control
  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      mem[mem_idx] <= wbuf[cnt_reg[PAGE_AW-1:0]];
    end
  end

  assign busy_o = wip_reg;
  assign armed_o = arm_reg;
  assign standby_o = pk2_reg & ~wip_reg;
endmodule : eesfe_dev

// ### hdl/eesfe_mst.sv
// eesfe_mst: bus master end that clocks bytes out and in over the link
`timescale 1ns/10ps
module eesfe_mst (
  eesfe_link_if.mst link,
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic cpol_i,
  input wire logic start_i,
  input wire logic [7:0] tx_len_i,
  input wire logic [7:0] rx_len_i,
  input wire logic [2:0] tail_bits_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic pause_req_i,
  input wire logic wp_n_i,
  output logic busy_o
);
  import eesfe_pkg::*;

  eesfe_host_t st_reg, st_next;
  logic [3:0] div_reg, div_next;
  logic sclk_reg, sclk_next;
  logic high_reg, high_next;
  logic pick_reg, pick_next;
  logic pause_reg, pause_next;
  logic [2:0] bit_reg, bit_next;
  logic [11:0] left_reg, left_next;
  logic [7:0] txl_reg, txl_next;
  logic [7:0] tsh_reg, tsh_next;
  logic [7:0] rsh_reg, rsh_next;
  logic [7:0] rxd_next;
  logic rxv_next;
  logic wp_reg;
  logic sd1_reg, sd2_reg;
  logic div_end, need_byte;

  assign div_end = (div_reg == LINK_DIV_LAST);
  // a byte is fetched from the user only at a byte boundary
  assign need_byte = (txl_reg != 8'h00);

  always_comb begin
    st_next = st_reg;
    div_next = div_end ? 4'h0 : div_reg + 4'h1;
    sclk_next = sclk_reg;
    high_next = high_reg;
    pick_next = pick_reg;
    pause_next = pause_reg;
    bit_next = bit_reg;
    left_next = left_reg;
    txl_next = txl_reg;
    tsh_next = tsh_reg;
    rsh_next = rsh_reg;
    rxd_next = rx_data_o;
    rxv_next = 1'b0;
    tx_ready_o = 1'b0;
    case (st_reg)
      H_IDLE: begin
        sclk_next = cpol_i;
        pick_next = 1'b1;
        if (div_end) begin
          div_next = div_reg;
        end
        left_next = {1'b0, tx_len_i, 3'h0} + {1'b0, rx_len_i, 3'h0} + {9'h000, tail_bits_i};
        if (start_i && div_end && left_next != 12'h000) begin
          txl_next = tx_len_i;
          bit_next = 3'h0;
          div_next = 4'h0;
          pick_next = 1'b0;
          st_next = H_LEAD;
        end
      end
      H_LEAD: begin
        if (div_end) begin
          tx_ready_o = need_byte & tx_valid_i;
          if (need_byte && !tx_valid_i) begin
            div_next = div_reg;
          end else begin
            tsh_next = need_byte ? tx_data_i : 8'h00;
            txl_next = need_byte ? txl_reg - 8'h01 : txl_reg;
            sclk_next = 1'b0;
            high_next = 1'b0;
            st_next = H_SHIFT;
          end
        end
      end
      H_SHIFT: begin
        if (div_end && !high_reg) begin
          // pause only while the clock is low
          pause_next = pause_req_i;
          // leaving pause costs one low phase, so pause_n never moves with a rising edge
          if (!pause_req_i && !pause_reg) begin
            sclk_next = 1'b1;
            high_next = 1'b1;
          end
        end else if (div_end) begin
          rsh_next = {rsh_reg[6:0], sd2_reg};
          bit_next = bit_reg + 3'h1;
          left_next = left_reg - 12'h001;
          tsh_next = {tsh_reg[6:0], 1'b0};
          if (bit_reg == 3'h7) begin
            rxd_next = rsh_next;
            rxv_next = 1'b1;
          end
          if (left_next == 12'h000) begin
            sclk_next = cpol_i;
            st_next = H_TAIL;
          end else if (bit_next == 3'h0 && need_byte && !tx_valid_i) begin
            div_next = div_reg;
            left_next = left_reg;
            bit_next = bit_reg;
            tsh_next = tsh_reg;
            rsh_next = rsh_reg;
            rxv_next = 1'b0;
          end else begin
            if (bit_next == 3'h0) begin
              tx_ready_o = need_byte;
              tsh_next = need_byte ? tx_data_i : 8'h00;
              txl_next = need_byte ? txl_reg - 8'h01 : txl_reg;
            end
            sclk_next = 1'b0;
            high_next = 1'b0;
          end
        end
      end
      H_TAIL: begin
        // select rises a half period after the last clock phase, a full period after the last edge when cpol_i is high
        if (div_end) begin
          pick_next = 1'b1;
          st_next = H_IDLE;
        end
      end
      default: begin
        st_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= H_IDLE;
      div_reg <= 4'h0;
      sclk_reg <= 1'b0;
      high_reg <= 1'b0;
      pick_reg <= 1'b1;
      pause_reg <= 1'b0;
      bit_reg <= 3'h0;
      left_reg <= 12'h000;
      txl_reg <= 8'h00;
      tsh_reg <= 8'h00;
      rsh_reg <= 8'h00;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      wp_reg <= 1'b1;
      sd1_reg <= 1'b0;
      sd2_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      sclk_reg <= sclk_next;
      high_reg <= high_next;
      pick_reg <= pick_next;
      pause_reg <= pause_next;
      bit_reg <= bit_next;
      left_reg <= left_next;
      txl_reg <= txl_next;
      tsh_reg <= tsh_next;
      rsh_reg <= rsh_next;
      rx_data_o <= rxd_next;
      rx_valid_o <= rxv_next;
      wp_reg <= wp_n_i;
      sd1_reg <= link.sdo_line;
      sd2_reg <= sd1_reg;
    end
  end

  assign link.sclk = sclk_reg;
  assign link.pick_n = pick_reg;
  assign link.sdi = tsh_reg[7];
  assign link.pause_n = ~pause_reg;
  assign link.wp_n = wp_reg;
  assign busy_o = (st_reg != H_IDLE);
endmodule : eesfe_mst

// ### sim/eesfe_chk.sv
// eesfe_chk: link-level assertions for the serial memory front end
`timescale 1ns/10ps
module eesfe_chk (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic sclk,
  input wire logic pick_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic pause_n
);
  logic seen_reg;
  logic seen_next;

  // remember a high select; until then a low select must not wake the output
  always_comb begin
    seen_next = seen_reg | pick_n;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= seen_next;
    end
  end

  // sampled on the fast clock, so edges of the link clock show as $rose/$fell
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  desel_float_a: assert property (pick_n |-> !sdo_oe)
    else $error("output driven while deselected");
  pause_float_a: assert property (!pause_n && !sclk |-> !sdo_oe)
    else $error("output driven while paused");
  out_fall_edge_a: assert property (
    sdo_oe && $past(sdo_oe) && (sdo != $past(sdo)) |-> $fell(sclk))
    else $error("read data changed away from a falling clock edge");
  oe_start_a: assert property ($rose(sdo_oe) |-> !sclk && !pick_n && pause_n)
    else $error("output enabled at a wrong moment");
  sdi_setup_a: assert property ($rose(sclk) && !pick_n |-> $stable(sdi))
    else $error("input data moved at the sampling edge");
  lead_idle_a: assert property ($fell(pick_n) |-> $stable(sclk) [*4])
    else $error("clock moved right after select fell");
  pause_clk_a: assert property (!pause_n |-> !sclk)
    else $error("clock high while paused");
  first_sel_a: assert property (!seen_reg |-> !sdo_oe)
    else $error("output driven before a select edge was seen");

  cover property ($rose(sdo_oe));
  cover property ($fell(pause_n));
  cover property ($rose(pick_n) && sclk);
endmodule : eesfe_chk

// ### sim/eeprom_serial_front_end_tb.sv
// eeprom_serial_front_end_tb: master and memory ends joined, driven from user sides
`timescale 1ns/10ps
module eeprom_serial_front_end_tb;
  import eesfe_pkg::*;
  typedef struct {
    logic cpol; int n; logic [31:0] b; int rx; logic [2:0] tl; int p;
    int c; int d; logic a; logic oe; logic [15:0] r;
  } eesfe_row_t;
  logic mclk_i, rst_b_i, cpol, start, tx_valid, tx_ready, rx_valid, pause_req, m_busy;
  logic d_busy, armed, standby, commit, drop;
  logic [7:0] tx_len, rx_len, tx_data, rx_data, ccmd, clen;
  logic [2:0] tail;
  logic [15:0] caddr, last;
  int errors, tests_run, ncom, ndrop, noe, pause_at, pcnt;
  // cpol, bytes, tx, rx, tail, pause, commits, drops, armed, oe, rx data
  eesfe_row_t rows[12] = '{
    '{1'b0, 1, 32'h06000000, 0, 3'h0, 0, 0, 0, 1'b1, 1'b0, 16'h0000},
    '{1'b0, 4, 32'h020010a5, 0, 3'h0, 0, 1, 0, 1'b0, 1'b0, 16'h0000},
    '{1'b1, 1, 32'h06000000, 0, 3'h0, 0, 0, 0, 1'b1, 1'b0, 16'h0000},
    '{1'b1, 4, 32'h0200113c, 0, 3'h0, 0, 1, 0, 1'b0, 1'b0, 16'h0000},
    '{1'b0, 4, 32'h02001177, 0, 3'h0, 0, 0, 1, 1'b0, 1'b0, 16'h0000},
    '{1'b0, 1, 32'h06000000, 0, 3'h0, 0, 0, 0, 1'b1, 1'b0, 16'h0000},
    '{1'b0, 3, 32'h02001100, 0, 3'h0, 0, 0, 1, 1'b1, 1'b0, 16'h0000},
    '{1'b0, 4, 32'h0200115a, 0, 3'h3, 0, 0, 1, 1'b1, 1'b0, 16'h0000},
    '{1'b1, 1, 32'h05000000, 1, 3'h0, 0, 0, 0, 1'b1, 1'b1, 16'h0002},
    '{1'b1, 3, 32'h03001000, 2, 3'h0, 0, 0, 0, 1'b1, 1'b1, 16'ha53c},
    '{1'b0, 3, 32'h03001000, 2, 3'h0, 330, 0, 0, 1'b1, 1'b1, 16'ha53c},
    '{1'b0, 3, 32'hff001000, 1, 3'h0, 0, 0, 0, 1'b1, 1'b0, 16'h0000}
  };

  eesfe_link_if link();
  eesfe_dev i_eesfe_dev (.link(link), .mclk_i(mclk_i), .rst_b_i(rst_b_i), .busy_o(d_busy),
    .armed_o(armed), .standby_o(standby), .commit_o(commit), .drop_o(drop),
    .commit_cmd_o(ccmd), .commit_addr_o(caddr), .commit_len_o(clen));
  eesfe_mst i_eesfe_mst (.link(link), .mclk_i(mclk_i), .rst_b_i(rst_b_i), .cpol_i(cpol),
    .start_i(start), .tx_len_i(tx_len), .rx_len_i(rx_len), .tail_bits_i(tail),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .pause_req_i(pause_req), .wp_n_i(1'b1), .busy_o(m_busy));
  eesfe_chk i_eesfe_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sclk(link.sclk),
    .pick_n(link.pick_n), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
    .pause_n(link.pause_n));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic final_report();
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // bounded wait for a flag to drop; a hang ends the run as a failure
  task automatic wait_low(input bit dev);
    int k;
    k = 0;
    while ((dev ? d_busy : m_busy) !== 1'b0 && k < 8000) begin
      @(posedge mclk_i);
      k++;
    end
    if (k == 8000) begin
      errors++;
      final_report();
    end
    repeat (8) @(posedge mclk_i);
  endtask : wait_low

  // counts pulses and output time; pause is held for 60 cycles from pause_at
  always @(posedge mclk_i) begin
    if (rx_valid) last <= {last[7:0], rx_data};
    if (commit) ncom <= ncom + 1;
    if (drop) ndrop <= ndrop + 1;
    if (link.sdo_oe) noe <= noe + 1;
    pcnt <= start ? 0 : pcnt + 1;
    pause_req <= pause_at != 0 && pcnt >= pause_at && pcnt < pause_at + 60;
    if (d_busy === 1'b1 || (link.pick_n === 1'b0 && pcnt > 4)) chk("standby", {15'h0, standby}, 16'h0000);
  end

  // one whole frame: bytes handed over on valid and ready, then settle
  task automatic run(eesfe_row_t r);
    int k, c0, d0, o0;
    c0 = ncom;
    d0 = ndrop;
    o0 = noe;
    cpol <= r.cpol;
    tx_len <= 8'(r.n);
    rx_len <= 8'(r.rx);
    tail <= r.tl;
    pause_at <= r.p;
    @(posedge mclk_i);
    start <= 1'b1;
    @(posedge mclk_i);
    start <= 1'b0;
    for (int i = 0; i < r.n; i++) begin
      tx_data <= r.b[31 - 8 * i -: 8];
      tx_valid <= 1'b1;
      k = 0;
      do begin
        @(posedge mclk_i);
        k++;
      end while (tx_ready !== 1'b1 && k < 3000);
      if (k == 3000) begin
        errors++;
        final_report();
      end
    end
    tx_valid <= 1'b0;
    wait_low(1'b0);
    wait_low(1'b1);
    chk("commit", 16'(ncom - c0), 16'(r.c));
    chk("drop", 16'(ndrop - d0), 16'(r.d));
    chk("armed", {15'h0, armed}, {15'h0, r.a});
    chk("oe", {15'h0, noe != o0}, {15'h0, r.oe});
    if (r.oe) chk("rx", r.rx > 1 ? last : {8'h00, last[7:0]}, r.r);
    if (r.c != 0) chk("addr", caddr, r.b[23:8]);
    if (r.c != 0) chk("len", {8'h00, clen}, 16'h0001);
  endtask : run

  initial begin
    rst_b_i = 1'b0;
    cpol = 1'b0;
    start = 1'b0;
    tx_len = 8'h00;
    rx_len = 8'h00;
    tail = 3'h0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk("standby", {15'h0, standby}, 16'h0001);
    chk("armed", {15'h0, armed}, 16'h0000);
    foreach (rows[i]) run(rows[i]);
    // a reset in mid-run must clear the arm latch, so the next store is refused
    run(rows[0]);
    rst_b_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk("armed", {15'h0, armed}, 16'h0000);
    run(rows[4]);
    final_report();
  end
endmodule : eeprom_serial_front_end_tb
